// ==== rtl/usc_pkg.sv ====
// package: register map, field positions and timing constants of the serial port
package usc_pkg;
  // register byte addresses
  localparam logic [7:0] REG_RX_CTRL = 8'h18; // receive_status_control
  localparam logic [7:0] REG_TX_CTRL = 8'h98; // transmit_status_control
  localparam logic [7:0] REG_BAUD = 8'h99; // baud_divisor_register
  localparam logic [7:0] REG_TX_DATA = 8'h9C; // transmit data (write)
  localparam logic [7:0] REG_RX_DATA = 8'h1C; // receive_data_register (read)
  localparam logic [7:0] REG_STATUS = 8'hA0; // pin ownership and buffer state
  localparam logic [7:0] REG_DIR = 8'hA4; // port_b_direction bits 2:1
  // transmit_status_control fields
  localparam int TX_CLK_SRC = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_D9 = 0;
  // receive_status_control fields
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE = 5;
  localparam int RX_CONT = 4;
  localparam int RX_ADDR = 3;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_ERROR_FLAG = 1;
  localparam int RX_D9 = 0;
  // direction register fields
  localparam int DIR_TX = 2;
  localparam int DIR_RX = 1;
  // reset values
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h06;
  localparam logic [7:0] TX_WRITE_MASK = 8'hF5; // empty flag and bit 3 not writable
  localparam logic [7:0] RX_WRITE_MASK = 8'hF8; // error and ninth flags not writable
  // baud prescale per bit period
  localparam int PRE_LOW = 64;
  localparam int PRE_HIGH = 16;
  localparam int PRE_SYNC = 4;
  localparam int SAMPLE_MID_LOW = 32;
  localparam int SAMPLE_MID_HIGH = 8;
  localparam int PRE_W = 7;
  typedef enum logic [2:0] {
    USC_IDLE = 3'b000,
    USC_START = 3'b001,
    USC_DATA = 3'b011,
    USC_NINTH = 3'b010,
    USC_STOP = 3'b110
  } usc_state_t;
  // decoded mode of the port
  typedef struct packed {
    logic on;
    logic sync;
    logic master;
    logic nine_tx;
    logic nine_rx;
  } usc_mode_t;
endpackage

// ==== rtl/usc_top.sv ====
// serial port control/status registers, baud generator, transmitter and receiver
`timescale 1ns/1ps
module usc_top
  import usc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe,
  input wire logic receive_data_pin_i,
  output logic receive_data_pin_o,
  output logic receive_data_pin_oe,
  output logic receive_data_valid
);
  // divisor register and timer are one byte wide; other widths are refused
  if (DIV_W != 8) begin : g_bad_width
    $error("baud divisor must be 8 bits");
  end

  // software-visible registers and buffers
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] baud_q;
  logic [7:0] dir_q;
  logic [8:0] tx_buf_q;
  logic tx_buf_full_q;
  logic [7:0] rx_buf_q;
  logic rx_buf_full_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic receive_ninth_bit_q;

  // shifters, frame state and bit counters
  logic [8:0] tsh_q;
  logic tsh_busy_q;
  logic [8:0] rsh_q;
  usc_state_t tst_q;
  usc_state_t rst_q;
  logic [3:0] tcnt_q;
  logic [3:0] rcnt_q;
  logic [PRE_W-1:0] tpre_q;
  logic [PRE_W-1:0] rpre_q;

  // baud timer, line drivers and pin synchronisers
  logic [7:0] brg_q;
  logic tx_line_q;
  logic ck_out_q;
  logic [1:0] rxd_sync_q;
  logic [1:0] ck_sync_q;
  logic ck_prev_q;
  logic srx_q;
  logic sync_txing_q;
  usc_mode_t mode;

  // bus decode; the slave answers in the access cycle with no wait
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_tx = (paddr == REG_TX_CTRL);
  wire hit_rx = (paddr == REG_RX_CTRL);
  wire hit_baud = (paddr == REG_BAUD);
  wire hit_txd = (paddr == REG_TX_DATA);
  wire hit_rxd = (paddr == REG_RX_DATA);
  wire hit_st = (paddr == REG_STATUS);
  wire hit_dir = (paddr == REG_DIR);
  wire mapped = hit_tx | hit_rx | hit_baud | hit_txd | hit_rxd | hit_st | hit_dir;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // pin ownership and mode decode
  wire pins_owned = rx_ctrl_q[RX_SERIAL_PORT_ENABLE] && dir_q[DIR_TX] && dir_q[DIR_RX];
  assign mode.on = pins_owned;
  assign mode.sync = tx_ctrl_q[TX_SYNC];
  assign mode.master = tx_ctrl_q[TX_SYNC] && tx_ctrl_q[TX_CLK_SRC];
  assign mode.nine_tx = tx_ctrl_q[TX_NINE];
  assign mode.nine_rx = rx_ctrl_q[RX_NINE];
  wire continuous_receive_enable = rx_ctrl_q[RX_CONT];
  wire single_receive_enable = rx_ctrl_q[RX_SINGLE] && mode.master;
  wire sync_rx_on = mode.sync && (continuous_receive_enable || single_receive_enable);
  wire tx_allowed = mode.on && tx_ctrl_q[TX_EN] && !(mode.sync && (continuous_receive_enable || single_receive_enable));
  wire async_rx_on = mode.on && !mode.sync && continuous_receive_enable;

  // baud timer: tick each X+1 clocks, bit period is a fixed prescale of ticks
  wire brg_tick = (brg_q == baud_q);
  wire [PRE_W-1:0] pre_bit = mode.sync ? PRE_W'(PRE_SYNC) :
                             (tx_ctrl_q[TX_HIGH] ? PRE_W'(PRE_HIGH) : PRE_W'(PRE_LOW));
  wire [PRE_W-1:0] pre_mid = tx_ctrl_q[TX_HIGH] ? PRE_W'(SAMPLE_MID_HIGH) : PRE_W'(SAMPLE_MID_LOW);
  wire [PRE_W-1:0] pre_last = pre_bit - PRE_W'(1);

  // timer resets on divisor write so a new rate starts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_q <= 8'h00;
    end else if (wr_en && hit_baud) begin
      brg_q <= 8'h00;
    end else begin
      brg_q <= brg_tick ? 8'h00 : brg_q + 8'h01;
    end
  end

  // link pins are foreign: two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync_q <= 2'b11;
      ck_sync_q <= 2'b11;
      ck_prev_q <= 1'b1;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], receive_data_pin_i};
      ck_sync_q <= {ck_sync_q[0], transmit_clock_pin_i};
      ck_prev_q <= ck_sync_q[1];
    end
  end
  // synchronised views of the two pins
  wire rxd = rxd_sync_q[1];
  wire ck_in = ck_sync_q[1];
  // slave clock edges; master uses its own clock line
  wire ck_rise_ext = ck_in && !ck_prev_q;
  wire ck_fall_ext = !ck_in && ck_prev_q;
  wire mst_half = brg_tick && (tpre_q == PRE_W'(1)); // half bit in sync master
  wire mst_full = brg_tick && (tpre_q == PRE_W'(PRE_SYNC - 1));
  wire s_shift = mode.master ? mst_full : ck_fall_ext; // data changes on falling edge in slave; master shifts one tick before its clock falls
  wire s_sample = mode.master ? mst_half : ck_rise_ext; // data sampled on rising edge

  // pin drive; disabled port leaves both pins to general purpose use
  assign transmit_clock_pin_o = mode.sync ? ck_out_q : tx_line_q;
  assign transmit_clock_pin_oe = mode.on && (mode.sync ? (mode.master && (tsh_busy_q || srx_q)) : 1'b1);
  assign receive_data_pin_o = tsh_q[0];
  assign receive_data_pin_oe = mode.on && mode.sync && sync_txing_q;

  // frame lengths; a buffered byte moves on only once the shifter is idle
  wire [3:0] tx_nbits = mode.nine_tx ? 4'h9 : 4'h8;
  wire [3:0] rx_nbits = mode.nine_rx ? 4'h9 : 4'h8;
  wire tx_load = tx_allowed && tx_buf_full_q && !tsh_busy_q;
  wire rxd_read = rd_en && hit_rxd;

  // transmitter: async frames on the baud ticks, sync bits on shift edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q <= USC_IDLE;
      tsh_q <= 9'h1FF;
      tsh_busy_q <= 1'b0;
      tcnt_q <= 4'h0;
      tpre_q <= '0;
      tx_line_q <= 1'b1;
      ck_out_q <= 1'b1;
      sync_txing_q <= 1'b0;
    end else if (!tx_allowed && !sync_rx_on || !mode.on) begin
      tst_q <= USC_IDLE;
      tsh_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
      ck_out_q <= 1'b1;
      sync_txing_q <= 1'b0;
      tpre_q <= '0;
    end else begin
      if (brg_tick) begin
        tpre_q <= (tpre_q == pre_last) ? '0 : tpre_q + PRE_W'(1);
        if (mode.master && (tsh_busy_q || srx_q)) begin
          if (tpre_q == PRE_W'(0)) ck_out_q <= 1'b0;
          if (mst_half) ck_out_q <= 1'b1;
        end
      end
      case (tst_q)
        USC_IDLE: begin
          if (tx_load) begin
            tsh_q <= {tx_ctrl_q[TX_D9], tx_buf_q[7:0]};
            tsh_busy_q <= 1'b1;
            tcnt_q <= 4'h0;
            tst_q <= mode.sync ? USC_DATA : USC_START;
            sync_txing_q <= mode.sync;
            tpre_q <= '0;
          end
        end
        USC_START: begin
          tx_line_q <= 1'b0;
          if (brg_tick && tpre_q == pre_last) tst_q <= USC_DATA;
        end
        USC_DATA: begin
          if (!mode.sync) begin
            tx_line_q <= tsh_q[0];
            if (brg_tick && tpre_q == pre_last) begin
              tsh_q <= {1'b1, tsh_q[8:1]};
              tcnt_q <= tcnt_q + 4'h1;
              if (tcnt_q == tx_nbits - 4'h1) tst_q <= USC_STOP;
            end
          end else if (s_shift) begin
            tsh_q <= {1'b1, tsh_q[8:1]};
            tcnt_q <= tcnt_q + 4'h1;
            if (tcnt_q == tx_nbits - 4'h1) begin
              tst_q <= USC_IDLE;
              tsh_busy_q <= 1'b0;
              sync_txing_q <= 1'b0;
            end
          end
        end
        USC_STOP: begin
          tx_line_q <= 1'b1;
          if (brg_tick && tpre_q == pre_last) begin
            tst_q <= USC_IDLE;
            tsh_busy_q <= 1'b0;
          end
        end
        default: tst_q <= USC_IDLE;
      endcase
    end
  end

  // receiver: mid-bit sampling in async, clock-edge sampling in sync
  wire rx_active = async_rx_on || (mode.on && sync_rx_on);
  wire rx_mid = brg_tick && (rpre_q == pre_mid);
  wire rx_bit = mode.sync ? s_sample : rx_mid;
  logic frame_done;
  logic stop_bad;
  assign frame_done = (rst_q == USC_STOP) && (mode.sync || rx_mid);
  assign stop_bad = !mode.sync && !rxd;
  // address detect only in async nine-bit mode
  wire addr_skip = !mode.sync && mode.nine_rx && rx_ctrl_q[RX_ADDR] && !rsh_q[8];
  wire rx_deliver = frame_done && !addr_skip;
  wire [8:0] rx_word = mode.nine_rx ? rsh_q : {1'b0, rsh_q[8:1]};

  // receive state; an unread buffer stops new frames only through the overrun flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= USC_IDLE;
      rsh_q <= 9'h000;
      rcnt_q <= 4'h0;
      rpre_q <= '0;
      srx_q <= 1'b0;
    end else if (!rx_active || overrun_error_flag_q) begin
      rst_q <= USC_IDLE;
      rpre_q <= '0;
      srx_q <= 1'b0;
    end else begin
      if (brg_tick) rpre_q <= (rpre_q == pre_last) ? '0 : rpre_q + PRE_W'(1);
      case (rst_q)
        USC_IDLE: begin
          rcnt_q <= 4'h0;
          srx_q <= mode.sync && mode.master;
          if (mode.sync) begin
            rst_q <= USC_DATA;
          end else if (!rxd) begin
            rst_q <= USC_START;
            rpre_q <= '0;
          end
        end
        USC_START: begin
          if (rx_mid) rst_q <= rxd ? USC_IDLE : USC_DATA; // false start dropped
        end
        USC_DATA: begin
          if (rx_bit) begin
            rsh_q <= {rxd, rsh_q[8:1]};
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q == rx_nbits - 4'h1) rst_q <= USC_STOP;
          end
        end
        USC_STOP: begin
          if (frame_done) begin
            rst_q <= USC_IDLE;
            srx_q <= 1'b0;
          end
        end
        default: rst_q <= USC_IDLE;
      endcase
    end
  end
  // valid follows the buffer so a poller need not read the status word
  assign receive_data_valid = rx_buf_full_q;

  // register file with hardware-set flags; set wins over a same-cycle clear except the overrun clear while the port enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctrl_q <= TX_CTRL_RST;
      rx_ctrl_q <= RX_CTRL_RST;
      baud_q <= 8'h00;
      dir_q <= DIR_RST;
      tx_buf_q <= 9'h000;
      tx_buf_full_q <= 1'b0;
      rx_buf_q <= 8'h00;
      rx_buf_full_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      receive_ninth_bit_q <= 1'b0;
    end else begin
      if (wr_en && hit_tx) begin
        tx_ctrl_q <= (pwdata[7:0] & TX_WRITE_MASK) | (tx_ctrl_q & ~TX_WRITE_MASK);
        tx_ctrl_q[3] <= 1'b0;
      end
      tx_ctrl_q[TX_EMPTY] <= !(tsh_busy_q && mode.on) && !tx_load;
      if (wr_en && hit_rx) begin
        rx_ctrl_q <= (pwdata[7:0] & RX_WRITE_MASK) | (rx_ctrl_q & ~RX_WRITE_MASK);
      end
      if (mode.sync && rst_q == USC_STOP && frame_done && !continuous_receive_enable) begin
        rx_ctrl_q[RX_SINGLE] <= 1'b0;
      end
      if (wr_en && hit_baud) baud_q <= pwdata[7:0];
      if (wr_en && hit_dir) dir_q <= pwdata[7:0] & DIR_RST;
      if (wr_en && hit_txd) begin
        tx_buf_q <= {1'b0, pwdata[7:0]};
        tx_buf_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full_q <= 1'b0;
      end
      if (rxd_read) rx_buf_full_q <= 1'b0;
      if (rx_deliver) begin
        if (rx_buf_full_q && !rxd_read) begin
          overrun_error_flag_q <= 1'b1;
        end else begin
          rx_buf_q <= rx_word[7:0];
          receive_ninth_bit_q <= rx_word[8];
          framing_error_flag_q <= stop_bad;
          rx_buf_full_q <= 1'b1;
        end
      end else if (wr_en && hit_rx && !pwdata[RX_CONT]) begin
        overrun_error_flag_q <= 1'b0;
      end
      if (!rx_ctrl_q[RX_SERIAL_PORT_ENABLE]) overrun_error_flag_q <= 1'b0;
    end
  end

  // read mux
  wire [7:0] tx_rd = {tx_ctrl_q[7:4], 1'b0, tx_ctrl_q[2:0]};
  wire [7:0] rx_rd = {rx_ctrl_q[7:3], framing_error_flag_q, overrun_error_flag_q, receive_ninth_bit_q};
  wire [7:0] st_rd = {4'h0, mode.on, tx_buf_full_q, rx_buf_full_q, tsh_busy_q};
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      if (hit_tx) prdata[7:0] = tx_rd;
      if (hit_rx) prdata[7:0] = rx_rd;
      if (hit_baud) prdata[7:0] = baud_q;
      if (hit_rxd) prdata[7:0] = rx_buf_q;
      if (hit_st) prdata[7:0] = st_rd;
      if (hit_dir) prdata[7:0] = dir_q;
    end
  end
  // upper bus lanes and the spare buffer bit carry nothing; folded so none dangles
  wire unused_bits = ^{pwdata[31:8], tx_buf_q[8]};
endmodule // usc_top

// ==== sim/usart_control_status_tb.sv ====
// self-checking bench of the serial port control and status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module usart_control_status_tb
  import usc_pkg::*;
;
  typedef struct { logic [7:0] a, d, e; logic x; } usc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic tx_o, tx_oe, rx_o, rx_oe, rx_valid, term_rx, term_ck;
  logic [7:0] paddr, bclks;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] got;
  int fail_count, checks_done, cyc;
  // write, expected readback, refusal
  usc_row_t rows [7] = '{'{REG_TX_CTRL, 8'hFF, 8'hF7, 1'b0}, '{REG_TX_CTRL, 8'h00, 8'h02, 1'b0},
    '{REG_RX_CTRL, 8'h07, 8'h00, 1'b0}, '{REG_BAUD, 8'hA5, 8'hA5, 1'b0}, '{REG_DIR, 8'h00, 8'h00, 1'b0},
    '{REG_DIR, 8'hFF, 8'h06, 1'b0}, '{8'h40, 8'h12, 8'h00, 1'b1}};
  // pins resolve from enables; the terminal's clock rests high when not in use
  wire tx_wire = tx_oe ? tx_o : term_ck;
  wire rx_wire = rx_oe ? rx_o : term_rx;
  usc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_clock_pin_i(tx_wire), .transmit_clock_pin_o(tx_o), .transmit_clock_pin_oe(tx_oe),
    .receive_data_pin_i(rx_wire), .receive_data_pin_o(rx_o), .receive_data_pin_oe(rx_oe),
    .receive_data_valid(rx_valid));
  usc_term u_term (.pclk(pclk), .bit_clks(bclks), .tx_line(tx_wire), .data_line(rx_wire), .rx_line(term_rx),
    .ck_line(term_ck));
  always #12.5 pclk = ~pclk;
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end
  // one apb transfer; holds the request until pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, rd & {24'hFFFFFF, m})
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 4000 && rx_valid !== 1'b1; i++) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bclks = 8'h10;
    {fail_count, checks_done, cyc} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].d);
      `CHK("wr_err", rows[i].x, err)
      rdchk(rows[i].a, 8'hFF, rows[i].e, "readback");
      `CHK("rd_err", rows[i].x, err)
    end
    $display("test registers done");
    // async high speed, divisor 0: 16 clocks a bit
    xfer(1'b1, REG_BAUD, 8'h00);
    xfer(1'b1, REG_RX_CTRL, 8'h90);
    xfer(1'b1, REG_TX_CTRL, 8'h24);
    repeat (2) @(posedge pclk);
    `CHK("tx_oe", 1'b1, tx_oe)
    fork
      u_term.grab(8, got);
      begin
        xfer(1'b1, REG_TX_DATA, 8'hA5);
        repeat (40) @(posedge pclk);
        rdchk(REG_TX_CTRL, 8'h02, 8'h00, "busy");
      end
    join
    `CHK("tx8", 9'h0A5, got)
    repeat (100) @(posedge pclk);
    rdchk(REG_TX_CTRL, 8'h02, 8'h02, "empty");
    xfer(1'b1, REG_TX_CTRL, 8'h65);
    fork
      u_term.grab(9, got);
      xfer(1'b1, REG_TX_DATA, 8'h3C);
    join
    `CHK("tx9", 9'h13C, got)
    repeat (100) @(posedge pclk);
    // low speed: 64 clocks a bit
    xfer(1'b1, REG_TX_CTRL, 8'h20);
    bclks = 8'h40;
    fork
      u_term.grab(8, got);
      xfer(1'b1, REG_TX_DATA, 8'h5A);
    join
    `CHK("tx_low", 9'h05A, got)
    repeat (400) @(posedge pclk);
    bclks = 8'h10;
    xfer(1'b1, REG_TX_CTRL, 8'h24);
    $display("test transmit done");
    u_term.send(9'h03C, 8, 1'b1);
    wait_valid();
    rdchk(REG_RX_CTRL, 8'h04, 8'h04, "framing_error_flag");
    rdchk(REG_RX_DATA, 8'hFF, 8'h3C, "rx_bad");
    u_term.send(9'h0C3, 8, 1'b0);
    wait_valid();
    rdchk(REG_RX_CTRL, 8'h04, 8'h00, "framing_error_flag_clr");
    rdchk(REG_RX_DATA, 8'hFF, 8'hC3, "rx8");
    u_term.send(9'h011, 8, 1'b0);
    u_term.send(9'h022, 8, 1'b0);
    repeat (20) @(posedge pclk);
    rdchk(REG_RX_CTRL, 8'h02, 8'h02, "overrun_error_flag");
    xfer(1'b1, REG_RX_CTRL, 8'h80);
    rdchk(REG_RX_CTRL, 8'h02, 8'h00, "overrun_error_flag_clr");
    rdchk(REG_RX_DATA, 8'hFF, 8'h11, "kept");
    $display("test receive done");
    xfer(1'b1, REG_RX_CTRL, 8'hD8);
    u_term.send(9'h055, 9, 1'b0);
    repeat (20) @(posedge pclk);
    `CHK("skipped", 1'b0, rx_valid)
    u_term.send(9'h181, 9, 1'b0);
    wait_valid();
    rdchk(REG_RX_CTRL, 8'h01, 8'h01, "ninth");
    rdchk(REG_RX_DATA, 8'hFF, 8'h81, "address");
    $display("test address detect done");
    // sync master send: clock from the baud timer, 4 clocks a bit
    xfer(1'b1, REG_RX_CTRL, 8'h80);
    xfer(1'b1, REG_TX_CTRL, 8'hB0);
    fork
      u_term.grab_sync(8, got);
      begin
        xfer(1'b1, REG_TX_DATA, 8'h96);
        repeat (4) @(posedge pclk);
        `CHK("sync_oe", 1'b1, rx_oe)
      end
    join
    `CHK("sync_tx", 9'h096, got)
    // single receive of an idle-high line; the enable clears itself
    xfer(1'b1, REG_RX_CTRL, 8'hA0);
    wait_valid();
    rdchk(REG_RX_CTRL, 8'h20, 8'h00, "single_clr");
    rdchk(REG_RX_DATA, 8'hFF, 8'hFF, "sync_rx");
    // slave receive on the terminal's clock with continuous enable
    xfer(1'b1, REG_TX_CTRL, 8'h10);
    xfer(1'b1, REG_RX_CTRL, 8'h90);
    u_term.feed_sync(8'h6B);
    wait_valid();
    rdchk(REG_RX_DATA, 8'hFF, 8'h6B, "slave_rx");
    xfer(1'b1, REG_RX_CTRL, 8'h80);
    xfer(1'b1, REG_TX_CTRL, 8'h24);
    $display("test sync done");
    xfer(1'b1, REG_DIR, 8'h02);
    repeat (2) @(posedge pclk);
    `CHK("dir_oe", 1'b0, tx_oe)
    xfer(1'b1, REG_DIR, 8'h06);
    xfer(1'b1, REG_RX_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("off_oe", 1'b0, tx_oe)
    $display("test pins done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(REG_TX_CTRL, 8'hFF, TX_CTRL_RST, "tx_rst");
    rdchk(REG_RX_CTRL, 8'hFE, RX_CTRL_RST, "rx_rst");
    rdchk(REG_BAUD, 8'hFF, 8'h00, "baud_rst");
    rdchk(REG_DIR, 8'hFF, DIR_RST, "dir_rst");
    $display("test reset done");
    final_report();
  end
endmodule // usart_control_status_tb
bind usc_top usc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transmit_clock_pin_o(transmit_clock_pin_o), .transmit_clock_pin_oe(transmit_clock_pin_oe),
  .receive_data_pin_oe(receive_data_pin_oe), .receive_data_valid(receive_data_valid));

// ==== sim/usc_sva.sv ====
// checker of bus answers and pin ownership at the serial port top
`timescale 1ns/1ps
module usc_sva
  import usc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmit_clock_pin_o,
  input wire logic transmit_clock_pin_oe,
  input wire logic receive_data_pin_oe,
  input wire logic receive_data_valid
);
  logic serial_port_enable_q, sync_q, own_q;
  logic [1:0] dir_q;
  // bus decode and pin ownership
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr = acc && pwrite;
  wire own = serial_port_enable_q && dir_q == 2'b11;
  wire mapped = paddr inside {REG_RX_CTRL, REG_TX_CTRL, REG_BAUD, REG_TX_DATA, REG_RX_DATA, REG_STATUS, REG_DIR};
  // shadow of enable, direction, mode; own_q lags so registered pin logic is allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_enable_q <= 1'b0;
      sync_q <= 1'b0;
      dir_q <= 2'b11;
      own_q <= 1'b0;
    end else begin
      own_q <= own;
      if (wr && paddr == REG_RX_CTRL) serial_port_enable_q <= pwdata[RX_SERIAL_PORT_ENABLE];
      if (wr && paddr == REG_TX_CTRL) sync_q <= pwdata[TX_SYNC];
      if (wr && paddr == REG_DIR) dir_q <= pwdata[DIR_TX:DIR_RX];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rd_upper; rd |-> prdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; acc && mapped |-> pready && !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_bit3; rd && paddr == REG_TX_CTRL |-> !prdata[3]; endproperty
  a_bit3: assert property (p_bit3) else $error("tx control bit 3 set");
  property p_pins_off; !own && !own_q |-> !transmit_clock_pin_oe && !receive_data_pin_oe; endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin driven while not owned");
  property p_rx_async; own && own_q && !sync_q |-> !receive_data_pin_oe; endproperty
  a_rx_async: assert property (p_rx_async) else $error("data pin driven in async");
  property p_empty_off; rd && paddr == REG_TX_CTRL && !own && !own_q |-> prdata[TX_EMPTY]; endproperty
  a_empty_off: assert property (p_empty_off) else $error("empty flag low while halted");
  property p_bit_len;
    $fell(transmit_clock_pin_o) && transmit_clock_pin_oe && !sync_q
      |-> (!transmit_clock_pin_o && transmit_clock_pin_oe) [*8];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("async bit too short");
  property p_valid_clr; rd && paddr == REG_RX_DATA |=> !receive_data_valid; endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid kept after read");
  c_frame: cover property ($fell(transmit_clock_pin_o) && transmit_clock_pin_oe);
  c_valid: cover property ($rose(receive_data_valid));
  c_err: cover property (pslverr);
  c_sync: cover property (receive_data_pin_oe);
endmodule // usc_sva

// ==== sim/usc_term.sv ====
// serial terminal model: sends and captures asynchronous frames
`timescale 1ns/1ps
module usc_term (
  input wire logic pclk,
  input wire logic [7:0] bit_clks,
  input wire logic tx_line,
  input wire logic data_line,
  output logic rx_line,
  output logic ck_line
);
  // lines rest high between frames
  initial rx_line = 1'b1;
  initial ck_line = 1'b1;
  // sync master capture: data read at each rising edge of the clock line
  task automatic grab_sync(input int n, output logic [8:0] d);
    d = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge tx_line);
      d[i] = data_line;
    end
  endtask
  // sync slave feed: 200 ns clock, data changes while the clock is low
  task automatic feed_sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      ck_line <= 1'b0;
      rx_line <= d[i];
      repeat (4) @(posedge pclk);
      ck_line <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    rx_line <= 1'b1;
  endtask
  // start, n bits lsb first, stop spoiled on request
  task automatic send(input logic [8:0] d, input int n, input bit bad);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= d[i];
      repeat (bit_clks) @(posedge pclk);
    end
    rx_line <= ~bad;
    repeat (bit_clks) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (bit_clks) @(posedge pclk);
  endtask
  // waits for a start bit, samples each bit mid-way; wrong rate shows as wrong data
  task automatic grab(input int n, output logic [8:0] d);
    d = '0;
    while (tx_line !== 1'b0) @(posedge pclk);
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge pclk);
      d[i] = tx_line;
    end
  endtask
endmodule // usc_term
